// ==== cdspr_pkg.sv ====
// Package: constants, register map and carriers of the pixel readout
package cdspr_pkg;
	// ****************
	// Widths and timing
	// ****************
	localparam int          SAMPLE_W   = 16;
	localparam int          NCH        = 8;
	localparam int          GAIN_FRAC  = 8;
	localparam logic [16:0] RAW_ROUND  = 17'h00400;
	localparam logic [15:0] IDX_MAX    = 16'hFFFF;
	localparam logic [15:0] PIX_MAX    = 16'hFFFF;
	// ****************
	// Register offsets
	// ****************
	localparam logic [11:0] OFS_CTRL    = 12'h000;
	localparam logic [11:0] OFS_RST_WIN = 12'h004;
	localparam logic [11:0] OFS_VID_WIN = 12'h008;
	localparam logic [11:0] OFS_GEOM    = 12'h00C;
	localparam logic [11:0] OFS_TAP     = 12'h010;
	localparam logic [11:0] OFS_TAP_OFS = 12'h014;
	localparam logic [11:0] OFS_RAW_LN  = 12'h018;
	localparam logic [11:0] OFS_RAW_PX  = 12'h01C;
	localparam logic [11:0] OFS_STATUS  = 12'h020;
	localparam logic [11:0] OFS_LAST    = 12'h024;
	// ****************
	// Field positions
	// ****************
	localparam int CTRL_RAW_EN = 0;
	localparam int CTRL_RAW_CH = 4;
	localparam int TAP_RIGHT   = 4;
	localparam int FIELD_HI    = 16;
	localparam int STATUS_DONE = 0;
	// ****************
	// Carriers
	// ****************
	typedef logic [NCH-1:0][SAMPLE_W-1:0] cdspr_adc_t;
	typedef struct packed {
		logic frame;
		logic line;
		logic pixel;
	} cdspr_mark_s;
	typedef struct packed {
		logic        raw_en;
		logic [3:0]  raw_ch;
		logic [15:0] rst_first;
		logic [15:0] rst_last;
		logic [15:0] vid_first;
		logic [15:0] vid_last;
		logic [15:0] pixels;
		logic [15:0] lines;
		logic [3:0]  tap_ch;
		logic        tap_right;
		logic [15:0] gain;
		logic [15:0] offset;
		logic [15:0] raw_ln_first;
		logic [15:0] raw_ln_last;
		logic [15:0] raw_px_first;
		logic [15:0] raw_samples;
	} cdspr_cfg_s;
	localparam cdspr_cfg_s CFG_RST = '{gain: 16'h0100, raw_ch: 4'h1, tap_ch: 4'h1, default: '0};
	// Channels count from 1; four per converter slot
	function automatic logic [2:0] chan_index(input logic [3:0] ch);
		logic [3:0] c;
		c = (ch == 4'h0) ? 4'h0 : ch - 4'h1;
		return c[2:0];
	endfunction : chan_index
endpackage : cdspr_pkg

// ==== cds_pixel_readout.sv ====
// Double sampled pixel readout with APB registers and raw capture
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Function
// [R1] Sequencer stays reset, outputting its first state, during configuration.
// [R2] Frame marker together with pixel marker starts a new frame.
// [R3] Frame and line markers count only while the pixel marker is high.
// [R4] Pixel is (reset mean minus video mean) times gain plus offset.
// [R5] Windows bounded by first/last indices from pixel start; all samples averaged.
// [R6] Normal mode emits each pixel as a 16-bit word.
// [R7] Frame assembled to configured pixels per line and lines per frame.
// [R8] One sample per clock; index equals cycles since the pixel marker.
// [R9] Raw capture stores selected channel over the line range from start pixel.
// [R10] Tap entry selects channel, starting side, gain and offset.
// [R11] Frame completion is visible to the host.
// [R12] Raw samples per line round up to a multiple of 1024.
// [R13] Raw samples are 16 bit; channels 1-4 first slot, 5-8 second.
// [R14] Out of range pixel values saturate to 0 or 65535.
module cds_pixel_readout (
	// Clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// APB slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [11:0]        paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	// Sequencer markers and samples
	input  wire cdspr_pkg::cdspr_mark_s mark,
	input  wire cdspr_pkg::cdspr_adc_t  adc,
	// Pixel stream
	output logic                    pix_valid,
	output logic      [15:0]        pix_data,
	output logic      [15:0]        pix_x,
	output logic      [15:0]        pix_y,
	output logic                    frame_done,
	// Raw stream
	output logic                    raw_valid,
	output logic      [15:0]        raw_data
);
	// ****************
	// Registers
	// ****************
	cdspr_pkg::cdspr_cfg_s cfg;
	logic        wr;
	logic        done_flag;
	logic [15:0] frame_cnt;
	logic [31:0] rd_data;
	logic        rd_ok;

	assign wr = psel && penable && pready && pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg <= cdspr_pkg::CFG_RST;
		end else if (wr) begin
			case (paddr)
				cdspr_pkg::OFS_CTRL: begin
					cfg.raw_en <= pwdata[cdspr_pkg::CTRL_RAW_EN];
					cfg.raw_ch <= pwdata[cdspr_pkg::CTRL_RAW_CH +: 4];
				end
				cdspr_pkg::OFS_RST_WIN: begin
					cfg.rst_first <= pwdata[15:0];
					cfg.rst_last  <= pwdata[31:16];
				end
				cdspr_pkg::OFS_VID_WIN: begin
					cfg.vid_first <= pwdata[15:0];
					cfg.vid_last  <= pwdata[31:16];
				end
				cdspr_pkg::OFS_GEOM: begin
					cfg.pixels <= pwdata[15:0];
					cfg.lines  <= pwdata[31:16];
				end
				cdspr_pkg::OFS_TAP: begin // [R10]
					cfg.tap_ch    <= pwdata[3:0];
					cfg.tap_right <= pwdata[cdspr_pkg::TAP_RIGHT];
					cfg.gain      <= pwdata[31:16];
				end
				cdspr_pkg::OFS_TAP_OFS: cfg.offset <= pwdata[15:0];
				cdspr_pkg::OFS_RAW_LN: begin
					cfg.raw_ln_first <= pwdata[15:0];
					cfg.raw_ln_last  <= pwdata[31:16];
				end
				cdspr_pkg::OFS_RAW_PX: begin
					cfg.raw_px_first <= pwdata[15:0];
					cfg.raw_samples  <= pwdata[31:16];
				end
				default: ;
			endcase
		end
	end

	always_comb begin
		rd_data = '0;
		rd_ok   = 1'b1;
		case (paddr)
			cdspr_pkg::OFS_CTRL:    rd_data = {24'h0, cfg.raw_ch, 3'h0, cfg.raw_en};
			cdspr_pkg::OFS_RST_WIN: rd_data = {cfg.rst_last, cfg.rst_first};
			cdspr_pkg::OFS_VID_WIN: rd_data = {cfg.vid_last, cfg.vid_first};
			cdspr_pkg::OFS_GEOM:    rd_data = {cfg.lines, cfg.pixels};
			cdspr_pkg::OFS_TAP:     rd_data = {cfg.gain, 11'h0, cfg.tap_right, cfg.tap_ch};
			cdspr_pkg::OFS_TAP_OFS: rd_data = {16'h0, cfg.offset};
			cdspr_pkg::OFS_RAW_LN:  rd_data = {cfg.raw_ln_last, cfg.raw_ln_first};
			cdspr_pkg::OFS_RAW_PX:  rd_data = {cfg.raw_samples, cfg.raw_px_first};
			cdspr_pkg::OFS_STATUS:  rd_data = {frame_cnt, 15'h0, done_flag};
			cdspr_pkg::OFS_LAST:    rd_data = {16'h0, pix_data};
			default:                rd_ok   = 1'b0;
		endcase
	end

	// Answer in the first cycle of the access phase, without wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !rd_ok;
			if (psel && !penable && !pwrite) begin
				prdata <= rd_data;
			end
		end
	end

	a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable |=> pready ##1 !pready) else $error("APB answer late");

	// ****************
	// Pixel framing
	// ****************
	logic        in_frame;
	logic        busy;
	logic        accept;
	logic        done;
	logic        last;
	logic [15:0] cx;
	logic [15:0] cy;
	logic [15:0] idx;
	logic [15:0] cur_idx;
	logic [15:0] end_idx;
	logic        s1_valid;
	logic        s1_last;

	// Markers outside a pixel marker are never looked at
	assign accept  = mark.pixel && (mark.frame || in_frame); // [R3]
	assign cur_idx = mark.pixel ? 16'h0000 : (idx == cdspr_pkg::IDX_MAX) ? idx : idx + 16'h0001; // [R8]
	assign end_idx = (cfg.rst_last > cfg.vid_last) ? cfg.rst_last : cfg.vid_last;
	assign done    = (accept || busy) && (cur_idx == end_idx);
	assign last    = (cx == cfg.pixels - 16'h0001) && (cy == cfg.lines - 16'h0001);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idx <= 16'h0000;
		end else begin
			idx <= cur_idx; // [R8]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cx <= 16'h0000;
			cy <= 16'h0000;
		end else if (accept) begin
			if (mark.frame) begin // [R2]
				cx <= 16'h0000;
				cy <= 16'h0000;
			end else if (mark.line) begin
				cx <= 16'h0000;
				cy <= cy + 16'h0001;
			end else begin
				cx <= cx + 16'h0001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_frame <= 1'b0;
			busy     <= 1'b0;
		end else begin
			if (accept && mark.frame) begin // [R2]
				in_frame <= 1'b1;
			end else if (done && last) begin // [R7]
				in_frame <= 1'b0;
			end
			busy <= (accept || busy) && !done;
		end
	end

	a_frame_start: assert property (@(posedge pclk) disable iff (!presetn)
		mark.pixel && mark.frame |=> in_frame && cx == 16'h0000 && cy == 16'h0000) // [R2]
		else $error("Frame marker did not restart frame");
	a_marker_gate: assert property (@(posedge pclk) disable iff (!presetn)
		!mark.pixel |=> $stable(cx) && $stable(cy)) // [R3]
		else $error("Position moved without pixel marker");
	a_sample_index: assert property (@(posedge pclk) disable iff (!presetn)
		mark.pixel ##1 !mark.pixel [*3] |-> cur_idx == 16'h0003) // [R8]
		else $error("Sample index not counting cycles");

	// ****************
	// Window averaging
	// ****************
	logic [15:0] smp;
	logic        in_r;
	logic        in_v;
	logic [31:0] sum_r;
	logic [31:0] sum_v;
	logic [16:0] cnt_r;
	logic [16:0] cnt_v;
	logic [31:0] next_sum_r;
	logic [31:0] next_sum_v;
	logic [16:0] next_cnt_r;
	logic [16:0] next_cnt_v;
	logic [31:0] q_r;
	logic [31:0] q_v;
	logic [15:0] mean_r;
	logic [15:0] mean_v;

	assign smp        = adc[cdspr_pkg::chan_index(cfg.tap_ch)]; // [R10]
	assign in_r       = cur_idx >= cfg.rst_first && cur_idx <= cfg.rst_last; // [R5]
	assign in_v       = cur_idx >= cfg.vid_first && cur_idx <= cfg.vid_last; // [R5]
	assign next_sum_r = (mark.pixel ? 32'h0 : sum_r) + (in_r ? {16'h0, smp} : 32'h0);
	assign next_sum_v = (mark.pixel ? 32'h0 : sum_v) + (in_v ? {16'h0, smp} : 32'h0);
	assign next_cnt_r = (mark.pixel ? 17'h0 : cnt_r) + {16'h0, in_r};
	assign next_cnt_v = (mark.pixel ? 17'h0 : cnt_v) + {16'h0, in_v};
	// Wide divide traded for exact means on any window length
	assign q_r = next_sum_r / {15'h0, (next_cnt_r == 17'h0) ? 17'h1 : next_cnt_r}; // [R5]
	assign q_v = next_sum_v / {15'h0, (next_cnt_v == 17'h0) ? 17'h1 : next_cnt_v}; // [R5]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sum_r <= 32'h0;
			sum_v <= 32'h0;
			cnt_r <= 17'h0;
			cnt_v <= 17'h0;
		end else begin
			sum_r <= next_sum_r;
			sum_v <= next_sum_v;
			cnt_r <= next_cnt_r;
			cnt_v <= next_cnt_v;
		end
	end

	a_window_count: assert property (@(posedge pclk) disable iff (!presetn)
		done && busy && cfg.rst_first <= cfg.rst_last && !mark.pixel
		|-> next_cnt_r == {1'b0, cfg.rst_last} - {1'b0, cfg.rst_first} + 17'h1) // [R5]
		else $error("Reset window sample count wrong");

	// ****************
	// Gain, offset, saturation
	// ****************
	logic [15:0]        s1_x;
	logic [15:0]        s1_y;
	logic signed [16:0] diff;
	logic signed [33:0] prod;
	logic signed [34:0] scaled;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_valid <= 1'b0;
			s1_last  <= 1'b0;
			s1_x     <= 16'h0000;
			s1_y     <= 16'h0000;
			mean_r   <= 16'h0000;
			mean_v   <= 16'h0000;
		end else begin
			s1_valid <= done && cx < cfg.pixels && cy < cfg.lines; // [R7]
			s1_last  <= done && last;
			s1_x     <= cfg.tap_right ? cfg.pixels - 16'h0001 - cx : cx; // [R10]
			s1_y     <= cy;
			mean_r   <= q_r[15:0];
			mean_v   <= q_v[15:0];
		end
	end

	assign diff   = $signed({1'b0, mean_r}) - $signed({1'b0, mean_v}); // [R4]
	assign prod   = diff * $signed({1'b0, cfg.gain}); // [R4]
	assign scaled = 35'(prod >>> cdspr_pkg::GAIN_FRAC) + 35'($signed(cfg.offset)); // [R4]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pix_valid <= 1'b0;
			pix_data  <= 16'h0000;
			pix_x     <= 16'h0000;
			pix_y     <= 16'h0000;
		end else begin
			pix_valid <= s1_valid;
			if (s1_valid) begin
				pix_x <= s1_x;
				pix_y <= s1_y;
				if (scaled < 35'sh0) begin // [R14]
					pix_data <= 16'h0000;
				end else if (scaled > $signed({19'h0, cdspr_pkg::PIX_MAX})) begin // [R14]
					pix_data <= cdspr_pkg::PIX_MAX;
				end else begin
					pix_data <= scaled[15:0]; // [R6]
				end
			end
		end
	end

	a_pix_floor: assert property (@(posedge pclk) disable iff (!presetn)
		s1_valid && scaled < 35'sh0 |=> pix_valid && pix_data == 16'h0000) // [R14]
		else $error("Negative pixel not floored");
	a_pix_value: assert property (@(posedge pclk) disable iff (!presetn)
		s1_valid && cfg.gain == 16'h0100 && cfg.offset == 16'h0000 && mean_r >= mean_v
		|=> pix_data == $past(mean_r) - $past(mean_v)) // [R4]
		else $error("Pixel difference wrong at unity gain");
	a_pix_geom: assert property (@(posedge pclk) disable iff (!presetn)
		pix_valid |-> pix_x < cfg.pixels && pix_y < cfg.lines) // [R7]
		else $error("Pixel outside frame geometry");

	// ****************
	// Frame completion
	// ****************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_done <= 1'b0;
			frame_cnt  <= 16'h0000;
			done_flag  <= 1'b0;
		end else begin
			frame_done <= s1_valid && s1_last; // [R11]
			if (s1_valid && s1_last) begin
				frame_cnt <= frame_cnt + 16'h0001; // [R11]
			end
			// Set beats a same-cycle write-one clear
			if (s1_valid && s1_last) begin
				done_flag <= 1'b1; // [R11]
			end else if (wr && paddr == cdspr_pkg::OFS_STATUS && pwdata[cdspr_pkg::STATUS_DONE]) begin
				done_flag <= 1'b0;
			end
		end
	end

	a_frame_seen: assert property (@(posedge pclk) disable iff (!presetn)
		s1_valid && s1_last |=> frame_done && done_flag && frame_cnt == $past(frame_cnt) + 16'h0001)
		else $error("Frame completion not shown"); // [R11]

	// ****************
	// Raw capture
	// ****************
	logic [16:0] raw_len;
	logic [16:0] raw_left;
	logic        raw_start;

	assign raw_len   = ({1'b0, cfg.raw_samples} + cdspr_pkg::RAW_ROUND - 17'h1)
		& ~(cdspr_pkg::RAW_ROUND - 17'h1); // [R12]
	assign raw_start = cfg.raw_en && accept && raw_len != 17'h0 && (mark.frame || mark.line
		? cfg.raw_px_first == 16'h0000 : cx + 16'h0001 == cfg.raw_px_first)
		&& (mark.frame ? 16'h0000 : mark.line ? cy + 16'h0001 : cy) >= cfg.raw_ln_first
		&& (mark.frame ? 16'h0000 : mark.line ? cy + 16'h0001 : cy) <= cfg.raw_ln_last; // [R9]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			raw_left  <= 17'h0;
			raw_valid <= 1'b0;
			raw_data  <= 16'h0000;
		end else begin
			raw_valid <= raw_start || raw_left != 17'h0; // [R9]
			raw_data  <= adc[cdspr_pkg::chan_index(cfg.raw_ch)]; // [R13]
			if (raw_start) begin
				raw_left <= raw_len - 17'h1; // [R12]
			end else if (raw_left != 17'h0) begin
				raw_left <= raw_left - 17'h1;
			end
		end
	end

	a_raw_round: assert property (@(posedge pclk) disable iff (!presetn)
		raw_start |=> raw_left[9:0] == 10'h3FF && raw_valid) // [R12]
		else $error("Raw length not a multiple of 1024");
	a_raw_chan: assert property (@(posedge pclk) disable iff (!presetn)
		raw_valid |-> raw_data == $past(adc[cdspr_pkg::chan_index(cfg.raw_ch)])) // [R13]
		else $error("Raw sample from wrong channel");

endmodule : cds_pixel_readout
`default_nettype wire

// ==== cdspr_seq_model.sv ====
// Sequencer and converter model driving markers and samples
`timescale 1ns/1ps
`default_nettype none
module cdspr_seq_model (
	// Clock and reset
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	// Pixel request
	input  wire logic                 go,
	input  wire logic [1:0]           kind,
	input  wire logic [2:0]           sel,
	input  wire logic [15:0]          rl,
	input  wire logic [15:0]          vl,
	output logic                      busy,
	// Markers and samples
	output var cdspr_pkg::cdspr_mark_s mark,
	output var cdspr_pkg::cdspr_adc_t  adc
);
	logic [4:0]  cnt;
	logic [15:0] noise;
	// ****************
	// Pixel timing
	// ****************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// Held in reset: all markers low, as the first program state
			busy  <= 1'b0;
			cnt   <= 5'h00;
			noise <= 16'hACE1;
		end else begin
			noise <= {noise[14:0], noise[15] ^ noise[13] ^ noise[12] ^ noise[10]};
			if (go && !busy) begin
				busy <= 1'b1;
				cnt  <= 5'h00;
			end else if (busy) begin
				cnt  <= cnt + 5'h01;
				busy <= (cnt != 5'h12);
			end
		end
	end
	// Flags rise early, as a real script keeps them, to show they are ignored then
	always_comb begin
		mark.frame = busy && (cnt <= 5'h03) && (kind == 2'h2);
		mark.line  = busy && (cnt <= 5'h03) && (kind == 2'h1);
		mark.pixel = busy && (cnt == 5'h03);
		for (int k = 0; k < cdspr_pkg::NCH; k++) begin
			adc[k] = noise ^ (16'(k) * 16'h1111);
		end
		if (busy && cnt >= 5'h03) begin
			adc[sel] = (cnt < 5'h0A) ? rl : vl;
		end
	end
endmodule : cdspr_seq_model
`default_nettype wire

// ==== cds_pixel_readout_bench.sv ====
// Self-checking bench of the pixel readout
`timescale 1ns/1ps
`default_nettype none
module cds_pixel_readout_bench;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed;
	logic        pix_valid, frame_done, raw_valid, go, busy, er, inf, rt;
	logic [15:0] pix_data, pix_x, pix_y, raw_data, rl, vl, adc_q, g, o, lastv, r, v;
	logic [1:0]  kind;
	logic [2:0]  sel;
	logic [48:0] e;
	logic [48:0] expq[$];
	cdspr_pkg::cdspr_mark_s mark;
	cdspr_pkg::cdspr_adc_t  adc;
	int          n_fail, compares, raw_cnt, px, py;
	// Last pass at unity gain and zero offset, so the plain difference check can fire
	localparam logic [15:0] GT [3] = '{16'h0100, 16'h0200, 16'h0100};
	localparam logic [15:0] OT [3] = '{16'h0064, 16'hFF9C, 16'h0000};
	localparam logic [3:0]  CT [3] = '{4'h1, 4'h6, 4'h3};
	localparam logic [1:0]  KT [7] = '{2'h2, 2'h0, 2'h0, 2'h1, 2'h0, 2'h0, 2'h0};
	cds_pixel_readout dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mark(mark), .adc(adc), .pix_valid(pix_valid), .pix_data(pix_data),
		.pix_x(pix_x), .pix_y(pix_y), .frame_done(frame_done), .raw_valid(raw_valid),
		.raw_data(raw_data));
	cdspr_seq_model seq (.pclk(pclk), .presetn(presetn), .go(go), .kind(kind), .sel(sel),
		.rl(rl), .vl(vl), .busy(busy), .mark(mark), .adc(adc));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	// ****************
	// Helpers
	// ****************
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	// Floor shift and clamp, never wrap
	function automatic logic [15:0] calc(input logic [15:0] a, b, gn, of);
		longint p;
		p = ((longint'(a) - longint'(b)) * longint'(gn)) >>> 8;
		p = p + longint'($signed(of));
		return (p < 0) ? 16'h0000 : (p > 65535) ? 16'hFFFF : p[15:0];
	endfunction : calc
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic close_out();
		if (n_fail == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : close_out
	task automatic hang();
		n_fail++;
		close_out();
	endtask : hang
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) hang();
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h00000000);
		check("prdata", rd, exp);
	endtask : rdchk
	task automatic pixel(input logic [1:0] k, input logic [15:0] a, input logic [15:0] b);
		int n;
		if (k == 2'h2) begin
			px = 0;
			py = 0;
			inf = 1'b1;
		end else if (k == 2'h1) begin
			px = 0;
			py++;
		end else px++;
		// Positions beyond the geometry produce nothing
		if (inf && px < 3 && py < 2) begin
			lastv = calc(a, b, g, o);
			expq.push_back({px == 2 && py == 1, lastv, rt ? 16'(2 - px) : 16'(px), 16'(py)});
		end
		@(posedge pclk);
		go   <= 1'b1;
		kind <= k;
		rl   <= a;
		vl   <= b;
		@(posedge pclk);
		go <= 1'b0;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (busy === 1'b1 && n < 40);
		if (busy !== 1'b0) hang();
	endtask : pixel
	task automatic settle();
		int n;
		n = 0;
		while ((expq.size() > 0 || raw_valid !== 1'b0) && n < 1500) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 1500) hang();
	endtask : settle
	// ****************
	// Monitor
	// ****************
	always @(posedge pclk) begin
		if (raw_valid === 1'b1) begin
			raw_cnt++;
			check("raw_data", {16'h0000, raw_data}, {16'h0000, adc_q});
		end
		adc_q <= adc[1];
		if (pix_valid === 1'b1) begin
			if (expq.size() == 0) check("pix_extra", 32'h00000001, 32'h00000000);
			else begin
				e = expq.pop_front();
				check("pix_data", {16'h0000, pix_data}, {16'h0000, e[47:32]});
				check("pix_x", {16'h0000, pix_x}, {16'h0000, e[31:16]});
				check("pix_y", {16'h0000, pix_y}, {16'h0000, e[15:0]});
				check("frame_done", {31'h0, frame_done}, {31'h0, e[48]});
			end
		end else if (frame_done !== 1'b0) check("frame_done", 32'h00000001, 32'h00000000);
	end
	// ****************
	// Sequence
	// ****************
	initial begin
		{presetn, psel, penable, pwrite, go, inf, rt} = '0;
		{paddr, pwdata, kind, sel, rl, vl, g, o, lastv} = '0;
		seed = 32'h7A88A331;
		{n_fail, compares, raw_cnt, px, py} = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(cdspr_pkg::OFS_CTRL, 32'h00000010);
		rdchk(cdspr_pkg::OFS_TAP, 32'h01000001);
		apb(1'b0, 12'h030, 32'h00000000);
		check("pslverr", {31'h0, er}, 32'h00000001);
		check("prdata", rd, 32'h00000000);
		apb(1'b1, cdspr_pkg::OFS_RST_WIN, 32'h00050002);
		apb(1'b1, cdspr_pkg::OFS_VID_WIN, 32'h000B0008);
		apb(1'b1, cdspr_pkg::OFS_GEOM, 32'h00020003);
		apb(1'b1, cdspr_pkg::OFS_CTRL, 32'h00000021);
		apb(1'b1, cdspr_pkg::OFS_RAW_LN, 32'h00010001);
		apb(1'b1, cdspr_pkg::OFS_RAW_PX, 32'h00010001);
		pixel(2'h0, 16'h1234, 16'h0034);
		for (int f = 0; f < 3; f++) begin
			g = GT[f];
			o = OT[f];
			rt = (f == 1);
			sel <= 3'(CT[f] - 4'h1);
			apb(1'b1, cdspr_pkg::OFS_TAP, {g, 11'h000, rt, CT[f]});
			apb(1'b1, cdspr_pkg::OFS_TAP_OFS, {16'h0000, o});
			for (int i = 0; i < 7; i++) begin
				r = 16'(xs());
				v = 16'(xs());
				if (f == 0 && i == 0) {r, v} = {16'hFFFF, 16'h0000};
				if (f == 0 && i == 1) {r, v} = {16'h0000, 16'hFFFF};
				pixel(KT[i], r, v);
			end
			settle();
			if (f == 0) check("raw_count", 32'(raw_cnt), 32'h00000400);
			rdchk(cdspr_pkg::OFS_STATUS, {16'(f + 1), 16'h0001});
			apb(1'b1, cdspr_pkg::OFS_STATUS, 32'h00000001);
			rdchk(cdspr_pkg::OFS_STATUS, {16'(f + 1), 16'h0000});
			rdchk(cdspr_pkg::OFS_LAST, {16'h0000, lastv});
			apb(1'b1, cdspr_pkg::OFS_CTRL, 32'h00000020);
		end
		close_out();
	end
endmodule : cds_pixel_readout_bench
`default_nettype wire
